// ### src/usart_mode_pkg.sv
// constants, register map and mode encoding of the serial mode control block
//
// Functional notes
// [R01] pins serial only with enable and both directions
// [R02] asynchronous mode sends and receives simultaneously
// [R03] synchronous mode is half duplex with clock
// [R04] three modes: async, sync master, sync slave
// [R05] transmit status and control register at 98h
// [R06] receive status and control register at 18h
// [R07] overrun holds until continuous receive cleared
`default_nettype none

package usart_mode_pkg;

	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [7:0] TX_CTRL_ADDR  = 8'h98;  // transmit_status_control
	localparam logic [7:0] RX_CTRL_ADDR  = 8'h18;  // receive_status_control
	localparam logic [7:0] TX_CTRL_RESET = 8'h00;  // writable transmit bits at reset
	localparam logic [7:0] RX_CTRL_RESET = 8'h00;  // writable receive bits at reset

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int TX_CLK_SRC_BIT  = 7;  // clock_source_select
	localparam int TX_NINE_BIT     = 6;  // nine_bit_transmit
	localparam int TX_EN_BIT       = 5;  // transmit_enable
	localparam int TX_SYNC_BIT     = 4;  // synchronous select
	localparam int TX_SPEED_BIT    = 2;  // high_speed_select
	localparam int TX_EMPTY_BIT    = 1;  // shift_register_empty
	localparam int TX_NINTH_BIT    = 0;  // ninth_transmit_bit
	localparam int RX_PORT_EN_BIT  = 7;  // serial_port_enable
	localparam int RX_NINE_BIT     = 6;  // nine_bit_receive
	localparam int RX_SINGLE_BIT   = 5;  // single_receive_enable
	localparam int RX_CONT_BIT     = 4;  // continuous_receive_enable
	localparam int RX_FRAME_BIT    = 2;  // framing_error_flag
	localparam int RX_OVERRUN_BIT  = 1;  // overrun_error_flag
	localparam int RX_NINTH_BIT    = 0;  // ninth_receive_bit
	localparam int DIR_TX_PIN_BIT  = 6;  // port_c_direction bit of tx_clock_pin
	localparam int DIR_RX_PIN_BIT  = 7;  // port_c_direction bit of rx_data_pin

	// -----------------------------------------------------------------
	// receive buffer shape
	// -----------------------------------------------------------------
	localparam int               WORD_W    = 9;     // received word incl. ninth bit
	localparam logic [1:0]       BUF_DEPTH = 2'h2;  // two-entry buffer

	// -----------------------------------------------------------------
	// operating mode, one-hot
	// -----------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_OFF    = 4'b0001,  // serial port not enabled
		MODE_ASYNC  = 4'b0010,  // full duplex asynchronous
		MODE_MASTER = 4'b0100,  // synchronous, clock driven out
		MODE_SLAVE  = 4'b1000   // synchronous, clock taken in
	} mode_type;

endpackage : usart_mode_pkg

`default_nettype wire

// ### src/usart_mode_control.sv
// mode control, status registers, pin claim and receive buffer of the serial unit
//
// The address-and-strobe port is this design's own decision.
`default_nettype none

module usart_mode_control (
	input  wire logic                 ref_clk,             // 250 MHz clock
	input  wire logic                 reset_n,             // async reset, active low
	input  wire logic [7:0]           reg_addr,            // register address
	input  wire logic [7:0]           reg_wdata,           // register write data
	input  wire logic                 reg_wr,              // write strobe
	input  wire logic                 reg_rd,              // read strobe
	output logic      [7:0]           reg_rdata,           // read data, cycle after strobe
	input  wire logic [7:0]           port_c_direction,    // port direction bits
	input  wire logic                 shift_register_empty,// transmit shifter empty
	input  wire logic                 ser_tx_data,         // serial data from transmitter
	input  wire logic                 ser_clk_out,         // master shift clock
	output logic                      ser_rx_data,         // serial data to receiver
	output logic                      ser_clk_in,          // slave shift clock
	input  wire logic                 rx_word_valid,       // receiver offers a word
	input  wire logic [8:0]           rx_word_data,        // received word
	input  wire logic                 rx_word_framing_error_flag,        // word had a framing error
	output logic                      rx_word_ready,       // buffer accepts word
	output logic                      rd_valid,            // buffered word available
	output logic      [8:0]           rd_data,             // buffered word
	input  wire logic                 rd_ready,            // consumer takes word
	input  wire logic                 tx_clock_pin_in,     // tx/clock pin level
	output logic                      tx_clock_pin_out,    // tx/clock pin drive
	output logic                      tx_clock_pin_oe_n,   // low while driving
	input  wire logic                 rx_data_pin_in,      // rx/data pin level
	output logic                      rx_data_pin_out,     // rx/data pin drive
	output logic                      rx_data_pin_oe_n,    // low while driving
	output usart_mode_pkg::mode_type  mode,                // operating mode
	output logic                      transmit_active,     // transmitter may run
	output logic                      receive_active,      // receiver may run
	output logic                      nine_bit_transmit,   // nine-bit frames out
	output logic                      nine_bit_receive,    // nine-bit frames in
	output logic                      ninth_transmit_bit,  // ninth bit to send
	output logic                      high_speed_select    // baud divider select
);

	// -----------------------------------------------------------------
	// register state
	// -----------------------------------------------------------------
	logic       clk_src_q;          // master clock source
	logic       nine_tx_q;          // nine-bit transmit
	logic       tx_en_q;            // transmit enable
	logic       sync_q;             // synchronous select
	logic       speed_q;            // high speed select
	logic       ninth_tx_q;         // ninth transmit bit
	logic       port_en_q;          // serial port enable
	logic       nine_rx_q;          // nine-bit receive
	logic       single_q;           // single receive enable
	logic       cont_q;             // continuous receive enable
	logic       overrun_q;          // overrun error flag
	logic [7:0] rdata_q;            // read data register
	logic       wr_tx;              // write to transmit register
	logic       wr_rx;              // write to receive register
	logic       claim;              // pins belong to serial unit
	logic       push;               // word enters buffer
	logic       pop;                // word leaves buffer
	logic       overrun_evt;        // word offered while full
	logic [9:0] buf_mem [0:1];      // {framing_error_flag, word} entries
	logic       wptr_q;             // write index
	logic       rptr_q;             // read index
	logic [1:0] count_q;            // entries held
	logic [9:0] head;               // oldest entry
	usart_mode_pkg::mode_type mode_d; // decoded mode

	assign wr_tx = reg_wr && (reg_addr == usart_mode_pkg::TX_CTRL_ADDR);
	assign wr_rx = reg_wr && (reg_addr == usart_mode_pkg::RX_CTRL_ADDR);

	// -----------------------------------------------------------------
	// mode decode and activity
	// -----------------------------------------------------------------
	// decode one of the three modes, or off
	always_comb begin
		if (!port_en_q) begin
			mode_d = usart_mode_pkg::MODE_OFF;
		end else if (!sync_q) begin
			mode_d = usart_mode_pkg::MODE_ASYNC;       // [R04]
		end else if (clk_src_q) begin
			mode_d = usart_mode_pkg::MODE_MASTER;      // [R04]
		end else begin
			mode_d = usart_mode_pkg::MODE_SLAVE;       // [R04]
		end
	end
	assign mode = mode_d;

	// transmit and receive permissions per mode
	always_comb begin
		case (mode_d)
			usart_mode_pkg::MODE_ASYNC: begin
				transmit_active = tx_en_q;                 // [R02]
				receive_active  = cont_q;                  // [R02]
			end
			usart_mode_pkg::MODE_MASTER: begin
				receive_active  = cont_q || single_q;      // [R07]
				transmit_active = tx_en_q && !receive_active; // [R03]
			end
			usart_mode_pkg::MODE_SLAVE: begin
				receive_active  = cont_q;
				transmit_active = tx_en_q && !cont_q;      // [R03]
			end
			default: begin
				transmit_active = 1'b0;
				receive_active  = 1'b0;
			end
		endcase
	end

	assign nine_bit_transmit  = nine_tx_q;
	assign nine_bit_receive   = nine_rx_q;
	assign ninth_transmit_bit = ninth_tx_q;
	assign high_speed_select  = speed_q;

	// -----------------------------------------------------------------
	// pin claim and drive
	// -----------------------------------------------------------------
	assign claim = port_en_q && port_c_direction[usart_mode_pkg::DIR_TX_PIN_BIT]
	               && port_c_direction[usart_mode_pkg::DIR_RX_PIN_BIT]; // [R01]

	// pin levels seen by the datapath, held idle high when not claimed
	assign ser_rx_data = claim ? rx_data_pin_in : 1'b1;
	assign ser_clk_in  = claim ? tx_clock_pin_in : 1'b1;

	// registered pin drive and enables
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_clock_pin_out  <= 1'b1;
			tx_clock_pin_oe_n <= 1'b1;
			rx_data_pin_out   <= 1'b1;
			rx_data_pin_oe_n  <= 1'b1;
		end else if (!claim) begin
			tx_clock_pin_oe_n <= 1'b1;                   // [R01]
			rx_data_pin_oe_n  <= 1'b1;                   // [R01]
		end else if (mode_d == usart_mode_pkg::MODE_ASYNC) begin
			tx_clock_pin_out  <= ser_tx_data;            // [R02]
			tx_clock_pin_oe_n <= 1'b0;
			rx_data_pin_oe_n  <= 1'b1;
		end else begin
			// synchronous: clock out only as master, data out only while sending
			tx_clock_pin_out  <= ser_clk_out;            // [R03]
			tx_clock_pin_oe_n <= !clk_src_q;
			rx_data_pin_out   <= ser_tx_data;
			rx_data_pin_oe_n  <= !transmit_active;       // [R03]
		end
	end

	// -----------------------------------------------------------------
	// control registers
	// -----------------------------------------------------------------
	// transmit control bits
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			{clk_src_q, nine_tx_q, tx_en_q, sync_q} <= usart_mode_pkg::TX_CTRL_RESET[7:4];
			speed_q    <= usart_mode_pkg::TX_CTRL_RESET[usart_mode_pkg::TX_SPEED_BIT];
			ninth_tx_q <= usart_mode_pkg::TX_CTRL_RESET[usart_mode_pkg::TX_NINTH_BIT];
		end else if (wr_tx) begin
			clk_src_q  <= reg_wdata[usart_mode_pkg::TX_CLK_SRC_BIT]; // [R05]
			nine_tx_q  <= reg_wdata[usart_mode_pkg::TX_NINE_BIT];
			tx_en_q    <= reg_wdata[usart_mode_pkg::TX_EN_BIT];
			sync_q     <= reg_wdata[usart_mode_pkg::TX_SYNC_BIT];
			speed_q    <= reg_wdata[usart_mode_pkg::TX_SPEED_BIT];
			ninth_tx_q <= reg_wdata[usart_mode_pkg::TX_NINTH_BIT];
		end
	end

	// receive control bits; hardware ends single receive after one word
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			{port_en_q, nine_rx_q, single_q, cont_q} <= usart_mode_pkg::RX_CTRL_RESET[7:4];
		end else begin
			if (wr_rx) begin
				port_en_q <= reg_wdata[usart_mode_pkg::RX_PORT_EN_BIT]; // [R06]
				nine_rx_q <= reg_wdata[usart_mode_pkg::RX_NINE_BIT];
				cont_q    <= reg_wdata[usart_mode_pkg::RX_CONT_BIT];
			end
			// software set wins over the hardware clear
			if (wr_rx && reg_wdata[usart_mode_pkg::RX_SINGLE_BIT]) begin
				single_q <= 1'b1;
			end else if (wr_rx) begin
				single_q <= 1'b0;
			end else if (push && !cont_q) begin
				single_q <= 1'b0;                            // [R07]
			end
		end
	end

	// overrun flag: sticky, cleared only while continuous receive is off
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			overrun_q <= 1'b0;
		end else if (overrun_evt) begin
			overrun_q <= 1'b1;                              // [R07]
		end else if (!cont_q) begin
			overrun_q <= 1'b0;                              // [R07]
		end
	end

	// -----------------------------------------------------------------
	// two-entry receive buffer
	// -----------------------------------------------------------------
	assign rx_word_ready = (count_q != usart_mode_pkg::BUF_DEPTH) && !overrun_q && receive_active;
	assign overrun_evt   = rx_word_valid && receive_active && (count_q == usart_mode_pkg::BUF_DEPTH);
	assign push          = rx_word_valid && rx_word_ready;
	assign rd_valid      = (count_q != 2'h0);
	assign pop           = rd_valid && rd_ready;
	assign head          = buf_mem[rptr_q];
	assign rd_data       = head[8:0];

	// storage of entries
	always_ff @(posedge ref_clk) begin
		if (push) begin
			buf_mem[wptr_q] <= {rx_word_framing_error_flag, rx_word_data};
		end
	end

	// pointers and fill count
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wptr_q  <= 1'b0;
			rptr_q  <= 1'b0;
			count_q <= 2'h0;
		end else begin
			if (push) begin
				wptr_q <= !wptr_q;
			end
			if (pop) begin
				rptr_q <= !rptr_q;
			end
			count_q <= count_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// -----------------------------------------------------------------
	// register read port
	// -----------------------------------------------------------------
	// data stand only in the cycle after the read strobe
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
		end else if (reg_rd && reg_addr == usart_mode_pkg::TX_CTRL_ADDR) begin
			rdata_q <= {clk_src_q, nine_tx_q, tx_en_q, sync_q, 1'b0, speed_q,
			            shift_register_empty, ninth_tx_q};      // [R05]
		end else if (reg_rd && reg_addr == usart_mode_pkg::RX_CTRL_ADDR) begin
			rdata_q <= {port_en_q, nine_rx_q, single_q, cont_q, 1'b0,
			            rd_valid && head[9], overrun_q, rd_valid && head[8]}; // [R06]
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign reg_rdata = rdata_q;

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	pin_claim_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R01]
		!claim |=> tx_clock_pin_oe_n && rx_data_pin_oe_n)
		else $error("pins driven without claim");

	async_duplex_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R02]
		(mode == usart_mode_pkg::MODE_ASYNC) && tx_en_q && cont_q |-> transmit_active && receive_active)
		else $error("async mode not full duplex");

	sync_half_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R03]
		sync_q |-> !(transmit_active && receive_active))
		else $error("sync mode both directions active");

	mode_onehot_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R04]
		$onehot(mode) && (port_en_q == (mode != usart_mode_pkg::MODE_OFF)))
		else $error("mode not one of the defined modes");

	tx_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R05]
		reg_rd && reg_addr == usart_mode_pkg::TX_CTRL_ADDR
		|=> !reg_rdata[3] && reg_rdata[1] == $past(shift_register_empty) && reg_rdata[5] == tx_en_q)
		else $error("transmit register read wrong");

	rx_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R06]
		reg_rd && reg_addr == usart_mode_pkg::RX_CTRL_ADDR
		|=> !reg_rdata[3] && reg_rdata[7] == port_en_q && reg_rdata[1] == $past(overrun_q))
		else $error("receive register read wrong");

	overrun_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R07]
		overrun_q && cont_q |=> overrun_q)
		else $error("overrun cleared while continuous receive on");

	cont_over_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R07]
		sync_q && port_en_q && cont_q |-> receive_active && !transmit_active)
		else $error("continuous receive not overriding");

endmodule : usart_mode_control

`default_nettype wire

// ### sim/serial_peer_model.sv
// far-side serial peer: resolves both shared pins and runs a framed shift clock
`default_nettype none

module serial_peer_model (
	input  wire logic ref_clk,           // system clock
	input  wire logic run_clk,           // peer shifts a frame
	input  wire logic peer_bit,          // bit the peer sends
	input  wire logic tx_clock_pin_out,  // device drive of clock pin
	input  wire logic tx_clock_pin_oe_n, // low while device drives it
	input  wire logic rx_data_pin_out,   // device drive of data pin
	input  wire logic rx_data_pin_oe_n,  // low while device drives it
	output logic      tx_clock_pin_in,   // resolved clock pin level
	output logic      rx_data_pin_in     // resolved data pin level
);
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_q = 1'b1; // peer clock, stands high outside frames

	// toggles only inside a frame
	always_ff @(posedge ref_clk) begin
		clk_q <= run_clk ? ~clk_q : 1'b1;
	end

	// device drive wins; otherwise the peer drives its own level
	assign tx_clock_pin_in = !tx_clock_pin_oe_n ? tx_clock_pin_out : clk_q;
	assign rx_data_pin_in  = !rx_data_pin_oe_n ? rx_data_pin_out : peer_bit;
endmodule : serial_peer_model

`default_nettype wire

// ### sim/usart_mode_control_tb.sv
// self-checking bench of the serial mode control block
`default_nettype none

module usart_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, sre = 1, tx_d = 1, clk_o = 1;
	logic [7:0] reg_addr = 0, reg_wdata = 0, port_c_direction = 0, reg_rdata;
	logic rx_valid = 0, rx_framing_error_flag = 0, rd_ready = 0, run_clk = 0, peer_bit = 1, rd_pend = 0;
	logic [8:0] rx_data = 0, rd_data, exp_rd[$], exp_word[$];
	logic rx_ready, rd_valid, ser_rx, ser_ck, tp_in, tp_out, tp_oe_n, dp_in, dp_out, dp_oe_n, tx_act, rx_act;
	logic nbt, nbr, ntb, hss; // register bits shown on the format outputs
	usart_mode_pkg::mode_type mode;
	int num_errors = 0, checks_done = 0, cycles = 0;
	logic [7:0] txv [3] = '{8'h20, 8'hb0, 8'h30}; // async, master, slave
	usart_mode_pkg::mode_type modes [3] = '{usart_mode_pkg::MODE_ASYNC, usart_mode_pkg::MODE_MASTER,
		usart_mode_pkg::MODE_SLAVE};

	usart_mode_control dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_c_direction(port_c_direction),
		.shift_register_empty(sre), .ser_tx_data(tx_d), .ser_clk_out(clk_o), .ser_rx_data(ser_rx),
		.ser_clk_in(ser_ck), .rx_word_valid(rx_valid), .rx_word_data(rx_data), .rx_word_framing_error_flag(rx_framing_error_flag),
		.rx_word_ready(rx_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
		.tx_clock_pin_in(tp_in), .tx_clock_pin_out(tp_out), .tx_clock_pin_oe_n(tp_oe_n),
		.rx_data_pin_in(dp_in), .rx_data_pin_out(dp_out), .rx_data_pin_oe_n(dp_oe_n), .mode(mode),
		.transmit_active(tx_act), .receive_active(rx_act), .nine_bit_transmit(nbt), .nine_bit_receive(nbr),
		.ninth_transmit_bit(ntb), .high_speed_select(hss));

	serial_peer_model peer (.ref_clk(ref_clk), .run_clk(run_clk), .peer_bit(peer_bit),
		.tx_clock_pin_out(tp_out), .tx_clock_pin_oe_n(tp_oe_n), .rx_data_pin_out(dp_out),
		.rx_data_pin_oe_n(dp_oe_n), .tx_clock_pin_in(tp_in), .rx_data_pin_in(dp_in));

	always #2 ref_clk = ~ref_clk;

	// ----------------------------------------
	// comparison, verdict and bus tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	// one bus cycle; every signal assigned once per edge
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, d);
	endtask : wr

	// notes the expected read data, the monitor compares it
	task automatic rd(input logic [7:0] a, input logic [8:0] e);
		exp_rd.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
	endtask : rd

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick

	// offers one word and waits for the buffer to take it
	task automatic push(input logic [8:0] d, input logic f);
		@(posedge ref_clk);
		rx_valid <= 1'b1;
		rx_data <= d;
		rx_framing_error_flag <= f;
		for (int k = 0; k < 20; k++) begin
			@(posedge ref_clk);
			if (rx_ready === 1'b1) break;
		end
		rx_valid <= 1'b0;
		exp_word.push_back(d);
	endtask : push

	// ----------------------------------------
	// monitor and hang guard
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (rd_pend) check("rdata", {1'b0, reg_rdata}, exp_rd.pop_front());
		if (rd_valid && rd_ready) check("word", rd_data, exp_word.pop_front());
		rd_pend <= reg_rd;
	end

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			num_errors++;
			finish_test();
		end
	end

	initial begin
		logic [7:0] w;
		logic a;
		void'($urandom(43445));
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		// reset values, unmapped place, random writes
		rd(8'h18, 9'h000);
		rd(8'h98, 9'h002);
		rd(8'h55, 9'h000);
		for (int i = 0; i < 8; i++) begin
			w = 8'($urandom);
			sre <= i[0];
			wr(8'h98, w);
			rd(8'h98, {1'b0, (w & 8'hf5) | {6'h00, i[0], 1'b0}});
			check("nine tx", 9'(nbt), 9'(w[6]));
			check("high speed", 9'(hss), 9'(w[2]));
			check("ninth tx", 9'(ntb), 9'(w[0]));
			wr(8'h18, w);
			rd(8'h18, {1'b0, w & 8'hf0});
			check("nine rx", 9'(nbr), 9'(w[6]));
		end
		// every mode with continuous receive on
		sre <= 1'b1;
		port_c_direction <= 8'hc0;
		wr(8'h18, 8'h90);
		for (int m = 0; m < 3; m++) begin
			wr(8'h98, txv[m]);
			tick(2);
			check("mode", 9'(mode), 9'(modes[m]));
			check("clk oe", 9'(tp_oe_n), 9'(m == 2));
			check("tx act", 9'(tx_act), 9'(m == 0));
			check("rx act", 9'(rx_act), 9'h001);
			check("data oe", 9'(dp_oe_n), 9'h001);
		end
		// slave takes the peer clock
		run_clk <= 1'b1;
		tick(2);
		a = ser_ck;
		tick(1);
		check("slave clk", 9'(ser_ck), 9'(!a));
		run_clk <= 1'b0;
		// async sends and receives together
		wr(8'h98, 8'h20);
		tx_d <= 1'($urandom);
		peer_bit <= 1'b0;
		tick(3);
		check("tx pin", 9'(tp_out), 9'(tx_d));
		check("rx in", 9'(ser_rx), 9'h000);
		// master transmits with receive off
		clk_o <= 1'b0;
		wr(8'h18, 8'h80);
		wr(8'h98, 8'hb0);
		tick(3);
		check("mst clk", 9'(tp_out), 9'h000);
		check("mst data oe", 9'(dp_oe_n), 9'h000);
		check("mst data", 9'(dp_out), 9'(tx_d));
		wr(8'h18, 8'ha0);
		tick(3);
		check("single rx", 9'(tx_act), 9'h000);
		check("single oe", 9'(dp_oe_n), 9'h001);
		// one word ends single receive, then drain it
		push(9'h0c3, 1'b0);
		rd_ready <= 1'b1;
		tick(2);
		rd_ready <= 1'b0;
		check("single done", 9'(rx_act), 9'h000);
		rd(8'h18, 9'h080);
		// pins released when one direction bit is clear
		port_c_direction <= 8'h40;
		tick(3);
		check("free clk oe", 9'(tp_oe_n), 9'h001);
		check("free rx", 9'(ser_rx), 9'h001);
		port_c_direction <= 8'hc0;
		wr(8'h18, 8'h10);
		tick(2);
		check("off", 9'(mode), 9'(usart_mode_pkg::MODE_OFF));
		// fill the buffer, overrun, clear, drain with stalls
		wr(8'h98, 8'h20);
		wr(8'h18, 8'h90);
		push(9'h1a5, 1'b1);
		push(9'h05a, 1'b0);
		tick(1);
		check("full", 9'(rx_ready), 9'h000);
		rx_valid <= 1'b1;
		tick(1);
		rx_valid <= 1'b0;
		tick(2);
		rd(8'h18, 9'h097);
		wr(8'h18, 8'h80);
		tick(2);
		rd(8'h18, 9'h085);
		wr(8'h18, 8'h90);
		for (int i = 0; i < 12; i++) begin
			rd_ready <= 1'($urandom);
			tick(1);
		end
		rd_ready <= 1'b1;
		for (int i = 0; i < 4; i++) push(9'($urandom), 1'b0);
		tick(3);
		check("empty", 9'(rd_valid), 9'h000);
		rd(8'h18, 9'h090);
		tick(3);
		finish_test();
	end
endmodule : usart_mode_control_tb

`default_nettype wire
